/* File: rtl/iob_regs.vh */
// Constants for the increment, jump and inclusive-OR executor
`ifndef IOB_REGS_VH
`define IOB_REGS_VH

// ==========================================================
// Opcode field layout and codes
`define IOB_OP_HI 13
`define IOB_OP6_LO 8
`define IOB_OP3_LO 11
`define IOB_OP4_LO 10
`define IOB_OP6_INC_SKIP 6'h0F
`define IOB_OP6_INC 6'h0A
`define IOB_OP6_OR_FILE 6'h04
`define IOB_OP3_JUMP 3'h5
`define IOB_OP4_OR_LIT 4'hE
`define IOB_DEST_BIT 7

// ==========================================================
// Operand field positions
`define IOB_LIT_HI 7
`define IOB_JMP_HI 10
`define IOB_ADDR_HI 6
`define IOB_PAGE_HI 4
`define IOB_PAGE_LO 3

// ==========================================================
// Reset values
`define IOB_W_RST 8'h00
`define IOB_PC_RST 13'h0000
`define IOB_Z_RST 1'b0
`define IOB_WDATA_RST 8'h00

`endif

/* File: rtl/iob_alu.v */
// Combinational ALU for increment and inclusive OR
`timescale 1ns/1ps
`default_nettype none
module iob_alu (
  // Operands
  input wire [7:0] opa,
  input wire [7:0] opb,
  input wire sel_or,
  // Result
  output wire [7:0] res,
  output wire zero
);
  wire [7:0] sum;
  assign sum = opa + 8'h01;
  assign res = sel_or ? (opa | opb) : sum;
  assign zero = (res == 8'h00);
endmodule // iob_alu
`default_nettype wire

/* File: rtl/iob_exec.v */
// Executor for increment, increment-skip, jump and inclusive-OR instructions
`timescale 1ns/1ps
`default_nettype none
`include "iob_regs.vh"
module iob_exec (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Instruction issue
  input wire instr_valid,
  input wire [13:0] instr,
  // Upper address latch
  input wire [7:0] upper_address_latch,
  // File register port
  output wire [6:0] file_addr,
  input wire [7:0] file_rdata,
  output reg file_we,
  output reg [7:0] file_wdata,
  // Core state
  output reg [7:0] w_reg,
  output reg zero_flag,
  output reg [12:0] pc,
  output reg pc_load,
  output reg nop_slot,
  output wire busy
);
  // ==========================================================
  // States, one-hot
  localparam ST_EXEC = 2'b01;
  localparam ST_FLUSH = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;

  // ==========================================================
  // Decoded instruction
  wire [5:0] op6;
  wire [2:0] op3;
  wire [3:0] op4;
  wire increment_skip_zero_op;
  wire increment_file_op;
  wire or_file_op;
  wire jump_op;
  wire or_literal_op;
  wire file_op;
  wire dest_file;
  wire [7:0] literal;
  wire [10:0] jump_target;
  wire [1:0] jump_page;
  wire do_exec;

  // ==========================================================
  // ALU operands and result
  wire [7:0] alu_a;
  wire [7:0] alu_b;
  wire alu_sel_or;
  wire [7:0] alu_res;
  wire alu_zero;

  // ==========================================================
  // Next values of the registers
  reg [7:0] next_w_reg;
  reg next_zero_flag;
  reg [12:0] next_pc;
  reg next_pc_load;
  reg next_nop_slot;
  reg next_file_we;
  reg [7:0] next_file_wdata;

  // ==========================================================
  // Opcode and operand fields
  assign op6 = instr[`IOB_OP_HI:`IOB_OP6_LO];
  assign op3 = instr[`IOB_OP_HI:`IOB_OP3_LO];
  assign op4 = instr[`IOB_OP_HI:`IOB_OP4_LO];
  assign literal = instr[`IOB_LIT_HI:0];
  assign jump_target = instr[`IOB_JMP_HI:0];
  assign jump_page = upper_address_latch[`IOB_PAGE_HI:`IOB_PAGE_LO];
  assign dest_file = instr[`IOB_DEST_BIT];
  assign file_addr = instr[`IOB_ADDR_HI:0];

  // ==========================================================
  // Instruction decode
  assign increment_skip_zero_op = (op6 == `IOB_OP6_INC_SKIP);
  assign increment_file_op = (op6 == `IOB_OP6_INC);
  assign or_file_op = (op6 == `IOB_OP6_OR_FILE);
  assign jump_op = (op3 == `IOB_OP3_JUMP);
  assign or_literal_op = (op4 == `IOB_OP4_OR_LIT);
  assign file_op = increment_skip_zero_op || increment_file_op ||
    or_file_op;

  // ==========================================================
  // Issue: instructions are ignored in the flushed slot
  assign do_exec = instr_valid && (state == ST_EXEC);
  assign busy = (state == ST_FLUSH);

  // ==========================================================
  // ALU operand select
  assign alu_sel_or = or_literal_op || or_file_op;
  assign alu_a = alu_sel_or ? w_reg : file_rdata;
  assign alu_b = or_literal_op ? literal : file_rdata;

  iob_alu u_alu (
    .opa(alu_a),
    .opb(alu_b),
    .sel_or(alu_sel_or),
    .res(alu_res),
    .zero(alu_zero)
  );

  // ==========================================================
  // Two-cycle sequencing for skip and jump
  always @* begin
    next_state = state;
    case (state)
      ST_EXEC: begin
        if (do_exec && (jump_op ||
            (increment_skip_zero_op && alu_zero))) begin
          next_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        next_state = ST_EXEC;
      end
      default: begin
        next_state = ST_EXEC;
      end
    endcase
  end

  // ==========================================================
  // Working register next value
  always @* begin
    next_w_reg = w_reg;
    if (do_exec) begin
      if (or_literal_op) begin
        next_w_reg = alu_res;
      end else if (file_op && !dest_file) begin
        next_w_reg = alu_res;
      end
    end
  end

  // ==========================================================
  // Zero flag next value; increment-skip leaves it alone
  always @* begin
    next_zero_flag = zero_flag;
    if (do_exec) begin
      if (or_literal_op || or_file_op || increment_file_op) begin
        next_zero_flag = alu_zero;
      end
    end
  end

  // ==========================================================
  // Program counter next value
  always @* begin
    next_pc = pc;
    next_pc_load = 1'b0;
    if (do_exec && jump_op) begin
      next_pc = {jump_page, jump_target};
      next_pc_load = 1'b1;
    end
  end

  // ==========================================================
  // File write-back next value
  always @* begin
    next_file_we = 1'b0;
    next_file_wdata = file_wdata;
    if (do_exec && file_op && dest_file) begin
      next_file_we = 1'b1;
      next_file_wdata = alu_res;
    end
  end

  // ==========================================================
  // Marker for the end of the flushed slot
  always @* begin
    next_nop_slot = busy;
  end

  // ==========================================================
  // Sequencer state register
  always @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Working register and zero flag
  always @(posedge clk) begin
    if (!rst_b) begin
      w_reg <= `IOB_W_RST;
      zero_flag <= `IOB_Z_RST;
    end else begin
      w_reg <= next_w_reg;
      zero_flag <= next_zero_flag;
    end
  end

  // ==========================================================
  // Program counter and its load pulse
  always @(posedge clk) begin
    if (!rst_b) begin
      pc <= `IOB_PC_RST;
      pc_load <= 1'b0;
    end else begin
      pc <= next_pc;
      pc_load <= next_pc_load;
    end
  end

  // ==========================================================
  // File write strobe and data
  always @(posedge clk) begin
    if (!rst_b) begin
      file_we <= 1'b0;
      file_wdata <= `IOB_WDATA_RST;
    end else begin
      file_we <= next_file_we;
      file_wdata <= next_file_wdata;
    end
  end

  // ==========================================================
  // No-op slot pulse
  always @(posedge clk) begin
    if (!rst_b) begin
      nop_slot <= 1'b0;
    end else begin
      nop_slot <= next_nop_slot;
    end
  end
endmodule // iob_exec
`default_nettype wire

/* File: verification/iob_exec_properties.sv */
// Checker for the increment, jump and OR executor
`timescale 1ns/1ps
`default_nettype none
module iob_exec_properties (
  // Watched ports
  input wire logic clk, rst_b, instr_valid, busy, pc_load, nop_slot,
  input wire logic file_we, zero_flag,
  input wire logic [13:0] instr,
  input wire logic [7:0] upper_address_latch, file_rdata, file_wdata, w_reg,
  input wire logic [12:0] pc
);
  wire logic tk = instr_valid && !busy;
  wire logic [5:0] op = instr[13:8];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_flush; busy ##1 nop_slot; endsequence
  a_jump_load:
    assert property (tk && instr[13:11] == 3'h5 |=> pc_load &&
      pc == {$past(upper_address_latch[4:3]), $past(instr[10:0])})
    else $error("jump target wrong");
  a_jump_flush:
    assert property (tk && instr[13:11] == 3'h5 |=> s_flush)
    else $error("jump not two cycles");
  a_skip_flush:
    assert property (tk && op == 6'h0F && file_rdata == 8'hFF |=> s_flush)
    else $error("zero skip missing");
  a_skip_w:
    assert property (tk && op == 6'h0F && !instr[7] |=>
      w_reg == $past(file_rdata) + 8'h01 && $stable(zero_flag))
    else $error("skip result wrong");
  a_inc_write:
    assert property (tk && op == 6'h0A && instr[7] |=> !busy && file_we &&
      file_wdata == $past(file_rdata) + 8'h01)
    else $error("increment write wrong");
  a_inc_zero:
    assert property (tk && op == 6'h0A |=>
      zero_flag == ($past(file_rdata) == 8'hFF))
    else $error("increment zero wrong");
  a_orlit_w:
    assert property (tk && instr[13:10] == 4'hE |=>
      w_reg == ($past(w_reg) | $past(instr[7:0])))
    else $error("literal OR wrong");
  a_orfile_w:
    assert property (tk && op == 6'h04 && !instr[7] |=>
      w_reg == ($past(w_reg) | $past(file_rdata)) && zero_flag == !w_reg)
    else $error("file OR wrong");
endmodule // iob_exec_properties
bind iob_exec iob_exec_properties u_chk (.*);
`default_nettype wire

/* File: verification/iob_exec_tb.sv */
// Testbench for the increment, jump and OR executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module iob_exec_tb;
  logic clk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] upper_address_latch = 8'h00, file_rdata = 8'h00;
  wire logic file_we, zero_flag, pc_load, nop_slot, busy;
  wire logic [7:0] file_wdata, w_reg;
  wire logic [6:0] file_addr;
  wire logic [12:0] pc;
  int err_total = 0, total_checks = 0, cyc = 0;
  iob_exec DUT (.*);
  always #5 clk = ~clk;
  task stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task ex(input logic [13:0] i, input logic [7:0] rd);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= i;
    file_rdata <= rd;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task t_or;
    ex(14'h38A5, 8'h00);
    `CHK(w_reg, 8'hA5);
    `CHK(zero_flag, 1'b0);
    ex(14'h0405, 8'h5A);
    `CHK(w_reg, 8'hFF);
    `CHK(file_we, 1'b0);
  endtask
  task t_skip;
    ex(14'h0F01, 8'hFF);
    `CHK(w_reg, 8'h00);
    `CHK(zero_flag, 1'b0);
    `CHK(busy, 1'b1);
    `CHK(file_addr, 7'h01);
    ex(14'h0F85, 8'h41);
    `CHK(file_we, 1'b1);
    `CHK(file_wdata, 8'h42);
    `CHK(w_reg, 8'h00);
    `CHK(busy, 1'b0);
  endtask
  task t_inc;
    ex(14'h0A85, 8'hFF);
    `CHK(file_wdata, 8'h00);
    `CHK(file_we, 1'b1);
    `CHK(zero_flag, 1'b1);
    `CHK(busy, 1'b0);
    ex(14'h0A05, 8'h7F);
    `CHK(w_reg, 8'h80);
    `CHK(zero_flag, 1'b0);
    `CHK(file_we, 1'b0);
    ex(14'h0485, 8'h01);
    `CHK(file_wdata, 8'h81);
    `CHK(file_we, 1'b1);
    `CHK(w_reg, 8'h80);
  endtask
  task t_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    `CHK(w_reg, 8'h00);
    `CHK(zero_flag, 1'b0);
    `CHK(pc, 13'h0000);
    `CHK(busy, 1'b0);
    `CHK(pc_load, 1'b0);
    `CHK(nop_slot, 1'b0);
    `CHK(file_we, 1'b0);
    ex(14'h3800, 8'h00);
    `CHK(w_reg, 8'h00);
    `CHK(zero_flag, 1'b1);
  endtask
  task t_jump;
    @(posedge clk);
    upper_address_latch <= 8'h10;
    ex(14'h2D55, 8'h00);
    `CHK(pc, 13'h1555);
    `CHK(pc_load, 1'b1);
    `CHK(busy, 1'b1);
    @(posedge clk);
    #1;
    `CHK(nop_slot, 1'b1);
    `CHK(busy, 1'b0);
    `CHK(pc_load, 1'b0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 500) begin
      err_total++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_or;
    t_skip;
    t_inc;
    t_jump;
    t_reset;
    stop_test;
  end
endmodule // iob_exec_tb
`default_nettype wire
